//--- rtl/ctae_consts.vh
// Purpose: Shared constants for the transfer/arithmetic execution datapath
// Assumes: Included by rtl/ctae_exec.v and by the two test files
// Notes: Opcode encodings and size codes are local choices
`ifndef CTAE_CONSTS_VH
`define CTAE_CONSTS_VH
// Operation codes
`define CTAE_OP_MOVRR 5'h00
`define CTAE_OP_MOVIMM 5'h01
`define CTAE_OP_LOAD 5'h02
`define CTAE_OP_STORE 5'h03
`define CTAE_OP_POP 5'h04
`define CTAE_OP_PUSH 5'h05
`define CTAE_OP_ADD 5'h06
`define CTAE_OP_SUB 5'h07
`define CTAE_OP_ADDC 5'h08
`define CTAE_OP_SUBC 5'h09
`define CTAE_OP_INC 5'h0A
`define CTAE_OP_DECR 5'h0B
`define CTAE_OP_ADDS 5'h0C
`define CTAE_OP_SUBW 5'h0D
`define CTAE_OP_BCDA 5'h0E
`define CTAE_OP_BCDS 5'h0F
`define CTAE_OP_MULU 5'h10
`define CTAE_OP_MULS 5'h11
`define CTAE_OP_PSREAD 5'h12
`define CTAE_OP_PSWRITE 5'h13
// Operand sizes
`define CTAE_SZ_B 2'h0
`define CTAE_SZ_W 2'h1
`define CTAE_SZ_L 2'h2
// Register selector: bit3 picks upper bank (E) or byte high (RnH)
`define CTAE_SP_IDX 3'h7
// Flag bit positions in the flag register
`define CTAE_FLG_C 0
`define CTAE_FLG_V 1
`define CTAE_FLG_Z 2
`define CTAE_FLG_N 3
`define CTAE_FLG_RST 4'h0
`define CTAE_REG_RST 32'h00000000
`endif

//--- rtl/ctae_exec.v
// Purpose: Execute data-transfer and arithmetic ops on the register file
// Assumes: Decoder presents one operation per START pulse; memory answers
//          each bus request with MEM_ACK some cycles later
// Notes: Register fetch happens in the issue cycle, so ops never overlap
`timescale 1ns/1ps
`default_nettype none
`include "ctae_consts.vh"
module ctae_exec (
  // Clock and reset
  input wire REF_CLK,
  input wire RESETN,
  // Operation from the decoder
  input wire START,
  input wire [4:0] OP,
  input wire [1:0] SIZE,
  input wire [3:0] RD_SEL,
  input wire [3:0] RS_SEL,
  input wire USE_IMM,
  input wire [31:0] IMM,
  input wire [23:0] EA_ADDR,
  // Memory bus
  output reg MEM_REQ,
  output reg MEM_WR,
  output reg [1:0] MEM_SIZE,
  output reg [23:0] MEM_ADDR,
  output reg [31:0] MEM_WDATA,
  input wire MEM_ACK,
  input wire [31:0] MEM_RDATA,
  // Status
  output wire BUSY,
  output reg DONE,
  output reg ILLEGAL,
  output wire [3:0] FLAGS,
  output wire [31:0] SP_VALUE
);
  localparam ST_IDLE = 3'b001;
  localparam ST_MEM = 3'b010;
  localparam ST_WB = 3'b100;

  reg [31:0] gr_r [0:7];
  reg [3:0] flg_r;
  reg [2:0] st_r;
  reg [2:0] st_nxt;
  reg [3:0] dst_r;
  reg [1:0] sz_r;
  reg pop_r;
  reg ld_r;
  integer i;

  // Read a register at the given size; sel[3] picks E half or high byte
  function [31:0] rd_sized;
    input [31:0] full;
    input [3:0] sel;
    input [1:0] sz;
    begin
      case (sz)
        `CTAE_SZ_B: rd_sized = {24'h000000,
                     sel[3] ? full[15:8] : full[7:0]};
        `CTAE_SZ_W: rd_sized = {16'h0000,
                     sel[3] ? full[31:16] : full[15:0]};
        default: rd_sized = full;
      endcase
    end
  endfunction

  // Merge a sized result into the old register value
  function [31:0] wr_sized;
    input [31:0] full;
    input [3:0] sel;
    input [1:0] sz;
    input [31:0] val;
    begin
      case (sz)
        `CTAE_SZ_B: wr_sized = sel[3] ?
                     {full[31:16], val[7:0], full[7:0]} :
                     {full[31:8], val[7:0]};
        `CTAE_SZ_W: wr_sized = sel[3] ?
                     {val[15:0], full[15:0]} :
                     {full[31:16], val[15:0]};
        default: wr_sized = val;
      endcase
    end
  endfunction

  wire [31:0] d_full = gr_r[RD_SEL[2:0]];
  wire [31:0] s_full = gr_r[RS_SEL[2:0]];
  wire [31:0] d_val = rd_sized(d_full, RD_SEL, SIZE);
  wire [31:0] s_reg = rd_sized(s_full, RS_SEL, SIZE);
  // Immediate operands arrive already zero-extended from 3..24 bits
  wire [31:0] s_val = USE_IMM ? IMM : s_reg;
  wire [31:0] sp = gr_r[`CTAE_SP_IDX];
  wire [31:0] step = (SIZE == `CTAE_SZ_L) ? 32'h00000004 : 32'h00000002;

  // Legality of the op/size/operand combination
  reg legal;
  always @* begin
    case (OP)
      `CTAE_OP_MOVRR, `CTAE_OP_MOVIMM, `CTAE_OP_LOAD, `CTAE_OP_STORE:
        legal = (SIZE != 2'h3);
      `CTAE_OP_POP, `CTAE_OP_PUSH:
        legal = (SIZE == `CTAE_SZ_W) || (SIZE == `CTAE_SZ_L);
      `CTAE_OP_ADD:
        legal = (SIZE != 2'h3);
      `CTAE_OP_SUB:
        legal = (SIZE != 2'h3) &&
                !(USE_IMM && SIZE == `CTAE_SZ_B);
      `CTAE_OP_ADDC, `CTAE_OP_SUBC, `CTAE_OP_BCDA, `CTAE_OP_BCDS:
        legal = (SIZE == `CTAE_SZ_B);
      `CTAE_OP_INC, `CTAE_OP_DECR:
        legal = (SIZE != 2'h3) && (IMM == 32'h1 ||
                (IMM == 32'h2 && SIZE != `CTAE_SZ_B));
      `CTAE_OP_ADDS, `CTAE_OP_SUBW:
        legal = (SIZE == `CTAE_SZ_L) && (IMM == 32'h1 ||
                IMM == 32'h2 || IMM == 32'h4);
      `CTAE_OP_MULU, `CTAE_OP_MULS:
        legal = (SIZE == `CTAE_SZ_B) || (SIZE == `CTAE_SZ_W);
      default:
        legal = 1'b0; // Peripheral sync ops fall here
    endcase
  end

  // Adder shared by add, subtract and their variants
  reg sub_sel;
  reg [31:0] b_op;
  reg cin;
  always @* begin
    sub_sel = 1'b0;
    b_op = s_val;
    cin = 1'b0;
    case (OP)
      `CTAE_OP_SUB: sub_sel = 1'b1;
      `CTAE_OP_ADDC: cin = flg_r[`CTAE_FLG_C];
      `CTAE_OP_SUBC: begin
        sub_sel = 1'b1;
        cin = flg_r[`CTAE_FLG_C];
      end
      `CTAE_OP_INC, `CTAE_OP_ADDS: b_op = IMM;
      `CTAE_OP_DECR, `CTAE_OP_SUBW: begin
        sub_sel = 1'b1;
        b_op = IMM;
      end
      default: ;
    endcase
  end

  wire [32:0] sum = sub_sel ?
    ({1'b0, d_val} - {1'b0, b_op} - {32'h0, cin}) :
    ({1'b0, d_val} + {1'b0, b_op} + {32'h0, cin});

  // Decimal adjust on the low byte using C and the nibble values
  reg [7:0] bcd;
  reg bcd_c;
  always @* begin
    bcd = d_val[7:0];
    bcd_c = flg_r[`CTAE_FLG_C];
    if (OP == `CTAE_OP_BCDA) begin
      if (d_val[3:0] > 4'h9)
        bcd = bcd + 8'h06;
      if (flg_r[`CTAE_FLG_C] || d_val[7:0] > 8'h99) begin
        bcd = bcd + 8'h60;
        bcd_c = 1'b1;
      end
    end else begin
      if (d_val[3:0] > 4'h9)
        bcd = bcd - 8'h06;
      if (flg_r[`CTAE_FLG_C])
        bcd = bcd - 8'h60;
    end
  end

  // Multipliers: operands taken at 8 or 16 bits, double-width product
  wire [15:0] ma = (SIZE == `CTAE_SZ_B) ?
    {{8{OP[0] & d_full[7]}}, d_full[7:0]} : d_full[15:0];
  wire [15:0] mb = (SIZE == `CTAE_SZ_B) ?
    {{8{OP[0] & s_reg[7]}}, s_reg[7:0]} : s_reg[15:0];
  wire [31:0] pu = {16'h0000, ma} * {16'h0000, mb};
  wire signed [31:0] ps = $signed({{16{ma[15]}}, ma}) *
                          $signed({{16{mb[15]}}, mb});
  wire [31:0] prod = (OP == `CTAE_OP_MULS) ? ps : pu;

  // Result value and its msb at the result size (double width for multiply)
  reg [31:0] res;
  reg arith;
  always @* begin
    res = sum[31:0];
    arith = 1'b1;
    case (OP)
      `CTAE_OP_MOVRR, `CTAE_OP_MOVIMM: begin
        res = s_val;
        arith = 1'b0;
      end
      `CTAE_OP_BCDA, `CTAE_OP_BCDS: res = {24'h000000, bcd};
      `CTAE_OP_MULU, `CTAE_OP_MULS: res = prod;
      `CTAE_OP_ADDS, `CTAE_OP_SUBW: arith = 1'b0;
      default: ;
    endcase
  end

  wire [1:0] rsz = (OP == `CTAE_OP_MULU || OP == `CTAE_OP_MULS) ?
    (SIZE + 2'h1) : SIZE;
  wire msb_r = (rsz == `CTAE_SZ_B) ? res[7] :
               (rsz == `CTAE_SZ_W) ? res[15] : res[31];
  wire msb_d = (SIZE == `CTAE_SZ_B) ? d_val[7] :
               (SIZE == `CTAE_SZ_W) ? d_val[15] : d_val[31];
  wire msb_b = (SIZE == `CTAE_SZ_B) ? b_op[7] :
               (SIZE == `CTAE_SZ_W) ? b_op[15] : b_op[31];
  wire zr = (rsz == `CTAE_SZ_B) ? (res[7:0] == 8'h00) :
            (rsz == `CTAE_SZ_W) ? (res[15:0] == 16'h0000) :
            (res == 32'h00000000);
  // Carry out is the bit just above the operand size
  wire [32:0] cx = {1'b0, d_val} ^ {1'b0, b_op} ^ sum;
  wire cy = (SIZE == `CTAE_SZ_B) ? cx[8] :
            (SIZE == `CTAE_SZ_W) ? cx[16] : sum[32];
  wire ov = sub_sel ? ((msb_d ^ msb_b) & (msb_d ^ msb_r)) :
                      (~(msb_d ^ msb_b) & (msb_d ^ msb_r));
  wire is_mul = (OP == `CTAE_OP_MULU) || (OP == `CTAE_OP_MULS);
  wire is_bcd = (OP == `CTAE_OP_BCDA) || (OP == `CTAE_OP_BCDS);
  wire is_incdec = (OP == `CTAE_OP_INC) || (OP == `CTAE_OP_DECR);
  wire is_x = (OP == `CTAE_OP_ADDC) || (OP == `CTAE_OP_SUBC);

  // Next flag value; increment/decrement keep C, multiply clears V and C
  reg [3:0] flg_nxt;
  always @* begin
    flg_nxt = flg_r;
    if (arith) begin
      flg_nxt[`CTAE_FLG_N] = msb_r;
      // Carry ops only clear Z so multi-byte zero tests chain
      flg_nxt[`CTAE_FLG_Z] = is_x ? (zr & flg_r[`CTAE_FLG_Z]) : zr;
      if (is_mul) begin
        flg_nxt[`CTAE_FLG_V] = 1'b0;
        flg_nxt[`CTAE_FLG_C] = 1'b0;
      end else if (is_bcd) begin
        flg_nxt[`CTAE_FLG_C] = bcd_c;
      end else begin
        flg_nxt[`CTAE_FLG_V] = ov;
        if (!is_incdec)
          flg_nxt[`CTAE_FLG_C] = cy;
      end
    end
  end

  // Sequencer: register ops finish in the issue cycle, memory ops wait
  wire is_mem = (OP == `CTAE_OP_LOAD) || (OP == `CTAE_OP_STORE) ||
                (OP == `CTAE_OP_POP) || (OP == `CTAE_OP_PUSH);
  always @* begin
    case (st_r)
      ST_IDLE: st_nxt = (START && legal && is_mem) ? ST_MEM : ST_IDLE;
      ST_MEM: st_nxt = MEM_ACK ? ST_WB : ST_MEM;
      ST_WB: st_nxt = ST_IDLE;
      default: st_nxt = ST_IDLE;
    endcase
  end
  assign BUSY = (st_r != ST_IDLE);
  assign FLAGS = flg_r;
  assign SP_VALUE = sp;

  // Datapath state update
  always @(posedge REF_CLK) begin
    if (!RESETN) begin
      st_r <= ST_IDLE;
      flg_r <= `CTAE_FLG_RST;
      for (i = 0; i < 8; i = i + 1)
        gr_r[i] <= `CTAE_REG_RST;
      MEM_REQ <= 1'b0;
      MEM_WR <= 1'b0;
      MEM_SIZE <= `CTAE_SZ_B;
      MEM_ADDR <= 24'h000000;
      MEM_WDATA <= 32'h00000000;
      DONE <= 1'b0;
      ILLEGAL <= 1'b0;
      dst_r <= 4'h0;
      sz_r <= `CTAE_SZ_B;
      pop_r <= 1'b0;
      ld_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      DONE <= 1'b0;
      ILLEGAL <= 1'b0;
      if (st_r == ST_IDLE && START) begin
        if (!legal) begin
          ILLEGAL <= 1'b1;
          DONE <= 1'b1;
        end else if (is_mem) begin
          MEM_REQ <= 1'b1;
          MEM_SIZE <= SIZE;
          MEM_WR <= (OP == `CTAE_OP_STORE) || (OP == `CTAE_OP_PUSH);
          MEM_WDATA <= d_val;
          dst_r <= RD_SEL;
          sz_r <= SIZE;
          pop_r <= (OP == `CTAE_OP_POP);
          ld_r <= (OP == `CTAE_OP_LOAD) || (OP == `CTAE_OP_POP);
          if (OP == `CTAE_OP_PUSH) begin
            // Pointer drops first, then data goes to the new top
            gr_r[`CTAE_SP_IDX] <= sp - step;
            MEM_ADDR <= sp[23:0] - step[23:0];
          end else if (OP == `CTAE_OP_POP)
            MEM_ADDR <= sp[23:0];
          else
            MEM_ADDR <= EA_ADDR;
        end else begin
          gr_r[RD_SEL[2:0]] <= wr_sized(d_full,
            is_mul ? {1'b0, RD_SEL[2:0]} : RD_SEL, rsz, res);
          flg_r <= flg_nxt;
          DONE <= 1'b1;
        end
      end
      if (st_r == ST_MEM && MEM_ACK)
        MEM_REQ <= 1'b0;
      if (st_r == ST_WB) begin
        if (ld_r)
          gr_r[dst_r[2:0]] <= wr_sized(gr_r[dst_r[2:0]], dst_r, sz_r,
                                        MEM_RDATA);
        // Pointer advances after the read; pop into SP keeps the data
        if (pop_r && dst_r[2:0] != `CTAE_SP_IDX)
          gr_r[`CTAE_SP_IDX] <= sp + ((sz_r == `CTAE_SZ_L) ?
                                32'h00000004 : 32'h00000002);
        DONE <= 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

//--- test/ctae_exec_properties.sv
// Purpose: Concurrent checks on the execution datapath ports
// Assumes: One clock domain, synchronous active-low reset
// Notes: Bound to every ctae_exec instance
`timescale 1ns/1ps
`default_nettype none
`include "ctae_consts.vh"
module ctae_exec_chk (
  // Clock and reset
  input wire REF_CLK,
  input wire RESETN,
  // Decoder side
  input wire START,
  input wire [4:0] OP,
  input wire [1:0] SIZE,
  input wire USE_IMM,
  input wire [31:0] IMM,
  // Memory and status
  input wire MEM_REQ,
  input wire MEM_WR,
  input wire [23:0] MEM_ADDR,
  input wire MEM_ACK,
  input wire BUSY,
  input wire DONE,
  input wire ILLEGAL,
  input wire [3:0] FLAGS,
  input wire [31:0] SP_VALUE
);
  default clocking cb @(posedge REF_CLK);
  endclocking
  default disable iff (!RESETN);
  // Issue qualifiers, only edges where the block takes a request
  wire go = START && !BUSY;
  wire go_b = go && SIZE == `CTAE_SZ_B;
  ill_done_a: assert property (ILLEGAL |-> DONE)
    else $error("illegal flag without done");
  ps_refuse_a: assert property (go && OP[4:1] == 4'h9 |=> ILLEGAL)
    else $error("peripheral sync op accepted");
  sub_imm_a: assert property (
    go_b && OP == `CTAE_OP_SUB && USE_IMM |=> ILLEGAL)
    else $error("byte subtract of immediate accepted");
  inc_two_a: assert property (
    go_b && OP == `CTAE_OP_INC && IMM == 32'h2 |=> ILLEGAL)
    else $error("byte step of two accepted");
  push_dec_a: assert property (
    go && OP == `CTAE_OP_PUSH && SIZE == `CTAE_SZ_L |=> MEM_REQ && MEM_WR &&
    SP_VALUE == $past(SP_VALUE) - 32'h4 && MEM_ADDR == SP_VALUE[23:0])
    else $error("push did not predecrement");
  req_hold_a: assert property (
    MEM_REQ && !MEM_ACK |=> MEM_REQ && $stable(MEM_ADDR))
    else $error("memory request dropped early");
  ack_done_a: assert property (
    MEM_REQ && MEM_ACK |=> !MEM_REQ ##1 DONE)
    else $error("no done after acknowledge");
  ill_keep_a: assert property (
    ILLEGAL |-> $stable(FLAGS) && $stable(SP_VALUE))
    else $error("refused op changed state");
  busy_mem_a: assert property (MEM_REQ |-> BUSY)
    else $error("memory request while not busy");
  // Main scenarios reached
  cov_push: cover property (go && OP == `CTAE_OP_PUSH ##1 MEM_REQ);
  cov_pop: cover property (go && OP == `CTAE_OP_POP ##1 MEM_REQ);
  cov_ill: cover property (ILLEGAL);
endmodule
bind ctae_exec ctae_exec_chk u_chk (.REF_CLK, .RESETN, .START, .OP, .SIZE,
  .USE_IMM, .IMM, .MEM_REQ, .MEM_WR, .MEM_ADDR, .MEM_ACK, .BUSY, .DONE,
  .ILLEGAL, .FLAGS, .SP_VALUE);
`default_nettype wire

//--- test/test_cpu_transfer_arith_exec.sv
// Purpose: Self-checking bench for the transfer/arithmetic datapath
// Assumes: Registers are read back by pushing them to the bench memory
// Notes: Inputs change on the falling edge only
`timescale 1ns/1ps
`default_nettype none
`include "ctae_consts.vh"
module test_cpu_transfer_arith_exec;
  reg REF_CLK = 1'b0;
  reg RESETN = 1'b0;
  reg START = 1'b0;
  reg [4:0] OP = 5'h00;
  reg [1:0] SIZE = 2'h0;
  reg [3:0] RD_SEL = 4'h0;
  reg [3:0] RS_SEL = 4'h0;
  reg USE_IMM = 1'b0;
  reg [31:0] IMM = 32'h0;
  reg [23:0] EA_ADDR = 24'h0;
  reg MEM_ACK = 1'b0;
  reg [31:0] MEM_RDATA = 32'h0;
  wire MEM_REQ, MEM_WR, BUSY, DONE, ILLEGAL;
  wire [1:0] MEM_SIZE;
  wire [23:0] MEM_ADDR;
  wire [31:0] MEM_WDATA, SP_VALUE;
  wire [3:0] FLAGS;
  integer err_count = 0, compares = 0, lat = 0;
  reg [31:0] m_wd, m_ad, m_ct, rd_v, f_s;
  reg got_ill;
  ctae_exec u_dut (.REF_CLK, .RESETN, .START, .OP, .SIZE, .RD_SEL, .RS_SEL,
    .USE_IMM, .IMM, .EA_ADDR, .MEM_REQ, .MEM_WR, .MEM_SIZE, .MEM_ADDR,
    .MEM_WDATA, .MEM_ACK, .MEM_RDATA, .BUSY, .DONE, .ILLEGAL, .FLAGS,
    .SP_VALUE);
  // 40 MHz clock
  always #12.5 REF_CLK = ~REF_CLK;
  // Compare and count
  task chk(input [31:0] seen, input [31:0] exp);
    begin
      compares = compares + 1;
      if (seen !== exp) begin
        err_count = err_count + 1;
        $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
    end
  endtask
  task final_report;
    begin
      $display("compares=%0d errors=%0d", compares, err_count);
      if (err_count == 0 && compares > 0)
        $display("RESULT: PASS");
      else
        $display("RESULT: FAIL");
      $finish;
    end
  endtask
  // Issue one op, act as memory (ack after lat cycles), wait for DONE
  task run(input [4:0] o, input [1:0] s, input [3:0] d, input [3:0] r,
    input u, input [31:0] i);
    integer k;
    reg acked;
    begin
      OP = o;
      SIZE = s;
      RD_SEL = d;
      RS_SEL = r;
      USE_IMM = u;
      IMM = i;
      MEM_RDATA = ~rd_v;
      START = 1'b1;
      @(negedge REF_CLK);
      START = 1'b0;
      acked = 1'b0;
      for (k = 0; k < 40 && !DONE; k = k + 1) begin
        // One assignment per edge, so the ack never glitches
        MEM_ACK = MEM_REQ && !acked && k >= lat;
        if (MEM_ACK) begin
          m_wd = MEM_WDATA;
          m_ad = {8'h00, MEM_ADDR};
          m_ct = {29'h0, MEM_WR, MEM_SIZE};
          MEM_RDATA = rd_v;
          acked = 1'b1;
        end
        @(negedge REF_CLK);
      end
      if (!DONE) begin
        err_count = err_count + 1;
        final_report;
      end
      got_ill = ILLEGAL;
      MEM_ACK = 1'b0;
      MEM_RDATA = ~rd_v;
      @(negedge REF_CLK);
    end
  endtask
  // Read a register by pushing it, then restore the stack pointer
  task rdreg(input [3:0] d, input [31:0] exp);
    begin
      run(`CTAE_OP_PUSH, `CTAE_SZ_L, d, d, 1'b0, 32'h0);
      chk(m_wd, exp);
      run(`CTAE_OP_MOVIMM, `CTAE_SZ_L, 4'h7, 4'h0, 1'b1, 32'h1000);
    end
  endtask
  // Refused op: flags must stay
  task illc(input [4:0] o, input [1:0] s, input u, input [31:0] i);
    begin
      f_s = {28'h0, FLAGS};
      run(o, s, 4'h1, 4'h2, u, i);
      chk({31'h0, got_ill}, 32'h1);
      chk({28'h0, FLAGS}, f_s);
    end
  endtask
  // Main sequence
  initial begin
    rd_v = 32'h0;
    repeat (20) @(negedge REF_CLK);
    RESETN = 1'b1;
    @(negedge REF_CLK);
    chk({28'h0, FLAGS}, 32'h0);
    chk(SP_VALUE, 32'h0);
    run(`CTAE_OP_MOVIMM, `CTAE_SZ_L, 4'h7, 4'h0, 1'b1, 32'h1000);
    chk(SP_VALUE, 32'h1000);
    run(`CTAE_OP_MOVIMM, `CTAE_SZ_L, 4'h1, 4'h0, 1'b1, 32'h7FFFFFFF);
    run(`CTAE_OP_ADD, `CTAE_SZ_L, 4'h1, 4'h0, 1'b1, 32'h1);
    chk({28'h0, FLAGS}, 32'hA);
    lat = 3;
    run(`CTAE_OP_PUSH, `CTAE_SZ_L, 4'h1, 4'h1, 1'b0, 32'h0);
    chk(m_wd, 32'h80000000);
    chk(m_ad, 32'hFFC);
    chk(m_ct, 32'h6);
    rd_v = 32'h12345678;
    run(`CTAE_OP_POP, `CTAE_SZ_L, 4'h2, 4'h2, 1'b0, 32'h0);
    chk(SP_VALUE, 32'h1000);
    chk(m_ct, 32'h2);
    rdreg(4'h2, 32'h12345678);
    EA_ADDR = 24'h123456;
    run(`CTAE_OP_STORE, `CTAE_SZ_L, 4'h2, 4'h2, 1'b0, 32'h0);
    chk(m_ad, 32'h123456);
    chk(m_wd, 32'h12345678);
    chk(m_ct, 32'h6);
    run(`CTAE_OP_PUSH, `CTAE_SZ_W, 4'h9, 4'h9, 1'b0, 32'h0);
    chk(m_wd, 32'h8000);
    chk(m_ad, 32'hFFE);
    chk(m_ct, 32'h5);
    rd_v = 32'hAAAA5555;
    run(`CTAE_OP_POP, `CTAE_SZ_W, 4'hA, 4'hA, 1'b0, 32'h0);
    chk(SP_VALUE, 32'h1000);
    run(`CTAE_OP_LOAD, `CTAE_SZ_B, 4'h2, 4'h2, 1'b0, 32'h0);
    chk(m_ct, 32'h0);
    run(`CTAE_OP_MOVRR, `CTAE_SZ_L, 4'h3, 4'h2, 1'b0, 32'h0);
    rdreg(4'h3, 32'h55555655);
    lat = 0;
    $display("test transfer done");
    run(`CTAE_OP_MOVIMM, `CTAE_SZ_L, 4'h3, 4'h0, 1'b1, 32'h0);
    run(`CTAE_OP_MOVIMM, `CTAE_SZ_B, 4'hB, 4'h0, 1'b1, 32'hAB);
    run(`CTAE_OP_MOVIMM, `CTAE_SZ_W, 4'hB, 4'h0, 1'b1, 32'hCDEF);
    rdreg(4'h3, 32'hCDEFAB00);
    run(`CTAE_OP_MOVIMM, `CTAE_SZ_L, 4'h6, 4'h0, 1'b1, 32'h90);
    run(`CTAE_OP_ADD, `CTAE_SZ_B, 4'h6, 4'h0, 1'b1, 32'h90);
    chk({28'h0, FLAGS}, 32'h3);
    run(`CTAE_OP_BCDA, `CTAE_SZ_B, 4'h6, 4'h0, 1'b0, 32'h0);
    rdreg(4'h6, 32'h80);
    run(`CTAE_OP_MOVIMM, `CTAE_SZ_L, 4'h6, 4'h0, 1'b1, 32'hFF);
    run(`CTAE_OP_ADD, `CTAE_SZ_B, 4'h6, 4'h0, 1'b1, 32'h1);
    chk({28'h0, FLAGS}, 32'h5);
    run(`CTAE_OP_ADDC, `CTAE_SZ_B, 4'h6, 4'h0, 1'b1, 32'h10);
    rdreg(4'h6, 32'h11);
    run(`CTAE_OP_MOVIMM, `CTAE_SZ_L, 4'h4, 4'h0, 1'b1, 32'hFF);
    run(`CTAE_OP_MOVIMM, `CTAE_SZ_L, 4'h5, 4'h0, 1'b1, 32'h2);
    run(`CTAE_OP_MULS, `CTAE_SZ_B, 4'h4, 4'h5, 1'b0, 32'h0);
    rdreg(4'h4, 32'hFFFE);
    run(`CTAE_OP_MULU, `CTAE_SZ_W, 4'h4, 4'h5, 1'b0, 32'h0);
    rdreg(4'h4, 32'h1FFFC);
    run(`CTAE_OP_SUB, `CTAE_SZ_B, 4'h6, 4'h5, 1'b0, 32'h0);
    run(`CTAE_OP_BCDS, `CTAE_SZ_B, 4'h6, 4'h0, 1'b0, 32'h0);
    rdreg(4'h6, 32'h09);
    run(`CTAE_OP_SUBC, `CTAE_SZ_B, 4'h6, 4'h0, 1'b1, 32'h10);
    chk({28'h0, FLAGS}, 32'h9);
    run(`CTAE_OP_DECR, `CTAE_SZ_B, 4'h6, 4'h0, 1'b0, 32'h1);
    run(`CTAE_OP_ADDS, `CTAE_SZ_L, 4'h6, 4'h0, 1'b0, 32'h4);
    chk({28'h0, FLAGS}, 32'h9);
    rdreg(4'h6, 32'hFC);
    run(`CTAE_OP_MOVIMM, `CTAE_SZ_L, 4'h0, 4'h0, 1'b1, 32'h0);
    run(`CTAE_OP_DECR, `CTAE_SZ_L, 4'h0, 4'h0, 1'b0, 32'h1);
    run(`CTAE_OP_INC, `CTAE_SZ_W, 4'h0, 4'h0, 1'b0, 32'h2);
    run(`CTAE_OP_SUBW, `CTAE_SZ_L, 4'h0, 4'h0, 1'b0, 32'h4);
    rdreg(4'h0, 32'hFFFEFFFD);
    $display("test arithmetic done");
    illc(`CTAE_OP_PSREAD, `CTAE_SZ_B, 1'b0, 32'h0);
    illc(`CTAE_OP_PSWRITE, `CTAE_SZ_B, 1'b0, 32'h0);
    illc(`CTAE_OP_SUB, `CTAE_SZ_B, 1'b1, 32'h1);
    illc(`CTAE_OP_ADDC, `CTAE_SZ_W, 1'b0, 32'h0);
    illc(`CTAE_OP_INC, `CTAE_SZ_B, 1'b0, 32'h2);
    illc(`CTAE_OP_ADDS, `CTAE_SZ_W, 1'b0, 32'h1);
    illc(`CTAE_OP_SUBW, `CTAE_SZ_L, 1'b0, 32'h3);
    illc(`CTAE_OP_BCDS, `CTAE_SZ_W, 1'b0, 32'h0);
    illc(`CTAE_OP_MULU, `CTAE_SZ_L, 1'b0, 32'h0);
    illc(`CTAE_OP_PUSH, `CTAE_SZ_B, 1'b0, 32'h0);
    $display("test refused done");
    final_report;
  end
endmodule
`default_nettype wire
